// ===== src/ebtp_pkg.sv
// shared constants of the break and trace probe block
package ebtp_pkg;
	localparam int          PROBE_W      = 12;
	localparam int          ADDR_W       = 16;
	localparam int          DATA_W       = 8;
	localparam int          BAUD_W       = 16;
	localparam logic        RST_OUT_HIGH = 1'b1;
	localparam logic [11:0] PROBE_RST    = 12'h000;
	localparam logic [15:0] ADDR_RST     = 16'h0000;
	localparam logic [7:0]  DATA_RST     = 8'h00;
	localparam logic [15:0] BAUD_RST     = 16'h0000;
	localparam logic [15:0] BAUD_ONE     = 16'h0001;
	localparam logic [15:0] BAUD_MAX     = 16'hFFFF;
	localparam int          KIND_PROGRAM_STORE_STROBE_N    = 0;
	localparam int          KIND_RD      = 1;
	localparam int          KIND_WR      = 2;

	typedef enum logic [2:0] {
		EBTP_IDLE = 3'b001,
		EBTP_RUN  = 3'b010,
		EBTP_HOLD = 3'b100
	} ebtp_exec_t;
endpackage

// ===== src/ebtp_cap_if.sv
// captured probe word passed from the capture stage to the break logic
`timescale 1ns/10ps
interface ebtp_cap_if;
	logic                         valid;
	logic [ebtp_pkg::PROBE_W-1:0] probe;
	logic [2:0]                   kind;
	modport src (output valid, output probe, output kind);
	modport dst (input valid, input probe, input kind);
endinterface

// ===== src/ebtp_probe_capture.sv
// synchronises probe pins and bus strobes, latches probes on a strobe fall
`timescale 1ns/10ps
module ebtp_probe_capture (
	input  wire logic                         clk,       // system clock
	input  wire logic                         rst,       // async reset
	input  wire logic [ebtp_pkg::PROBE_W-1:0] probe_pin, // logic probe pins
	input  wire logic [2:0]                   strobe_n,  // program store, read, write
	ebtp_cap_if.src                           cap        // captured word
);
	logic [ebtp_pkg::PROBE_W-1:0] p1_q, p2_q, cap_q, cap_d;
	logic [2:0]                   s1_q, s2_q, s3_q, fall, kind_q, kind_d;
	logic                         vld_q, vld_d;

	assign fall = s3_q & ~s2_q;

	always_comb begin
		cap_d  = cap_q;
		kind_d = kind_q;
		vld_d  = 1'b0;
		if (|fall) begin
			cap_d  = p2_q;
			kind_d = fall;
			vld_d  = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			p1_q   <= ebtp_pkg::PROBE_RST;
			p2_q   <= ebtp_pkg::PROBE_RST;
			s1_q   <= 3'h7;
			s2_q   <= 3'h7;
			s3_q   <= 3'h7;
			cap_q  <= ebtp_pkg::PROBE_RST;
			kind_q <= 3'h0;
			vld_q  <= 1'b0;
		end else begin
			p1_q   <= probe_pin;
			p2_q   <= p1_q;
			s1_q   <= strobe_n;
			s2_q   <= s1_q;
			s3_q   <= s2_q;
			cap_q  <= cap_d;
			kind_q <= kind_d;
			vld_q  <= vld_d;
		end
	end

	assign cap.valid = vld_q;
	assign cap.probe = cap_q;
	assign cap.kind  = kind_q;

	a_capture_on_fall: assert property (@(posedge clk) disable iff (rst)
		(|fall) |=> (vld_q && cap_q == $past(p2_q))) else $error("probe not captured on strobe fall");
endmodule // ebtp_probe_capture

// ===== src/ebtp_addr_rebuild.sv
// rebuilds the fetch address from the socket lines and the latched low byte
`timescale 1ns/10ps
module ebtp_addr_rebuild (
	input  wire logic                         clk,        // system clock
	input  wire logic                         rst,        // async reset
	input  wire logic [ebtp_pkg::ADDR_W-1:0]  sock_addr,  // socket address lines
	input  wire logic [ebtp_pkg::DATA_W-1:0]  sock_data,  // socket data lines
	input  wire logic                         ale_pin,    // address latch strobe
	input  wire logic                         prog_n_pin, // program store strobe
	output logic                              fetch,      // one-cycle fetch pulse
	output logic [ebtp_pkg::ADDR_W-1:0]       fetch_addr  // rebuilt address
);
	logic [ebtp_pkg::ADDR_W-1:0] a1_q, a2_q, fa_q, fa_d;
	logic [ebtp_pkg::DATA_W-1:0] d1_q, d2_q, lo_q, lo_d;
	logic [2:0]                  ale_q, ps_q;
	logic                        f_q, f_d;

	always_comb begin
		lo_d = lo_q;
		fa_d = fa_q;
		f_d  = 1'b0;
		if (ale_q[2] && !ale_q[1]) begin
			lo_d = d2_q;
		end
		if (ps_q[2] && !ps_q[1]) begin
			fa_d = {a2_q[ebtp_pkg::ADDR_W-1:ebtp_pkg::DATA_W], lo_q};
			f_d  = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			a1_q  <= ebtp_pkg::ADDR_RST;
			a2_q  <= ebtp_pkg::ADDR_RST;
			d1_q  <= ebtp_pkg::DATA_RST;
			d2_q  <= ebtp_pkg::DATA_RST;
			ale_q <= 3'h0;
			ps_q  <= 3'h7;
			lo_q  <= ebtp_pkg::DATA_RST;
			fa_q  <= ebtp_pkg::ADDR_RST;
			f_q   <= 1'b0;
		end else begin
			a1_q  <= sock_addr;
			a2_q  <= a1_q;
			d1_q  <= sock_data;
			d2_q  <= d1_q;
			ale_q <= {ale_q[1:0], ale_pin};
			ps_q  <= {ps_q[1:0], prog_n_pin};
			lo_q  <= lo_d;
			fa_q  <= fa_d;
			f_q   <= f_d;
		end
	end

	assign fetch      = f_q;
	assign fetch_addr = fa_q;

	a_low_byte_latch: assert property (@(posedge clk) disable iff (rst)
		(ale_q[2] && !ale_q[1]) |=> (lo_q == $past(d2_q))) else $error("low address byte not latched");
endmodule // ebtp_addr_rebuild

// ===== src/ebtp_top.sv
// break and trace probe logic of the emulator
// Functional notes
// - twelve probe inputs feed the trace record and the break compare
// - probes are captured on the fall of program store, read or write strobe
// - probe breaks are computed only from captured probe words
// - two trigger outputs follow the first and second break events
// - the first trigger output also lights the trigger indicator
// - the second trigger output is active low, the first active high
// - an external reset during running resets the emulated processor
// - break evaluation continues during and after external reset
// - with reset held, nothing runs and the running indicator stays dark
// - manual halt under held reset forces hardware reset and reports failure
// - a reset output controls the target processor via its reset pin
// - the low address byte is latched from data lines by the latch strobe
// - sixteen address lines, eight data lines and program strobe come from socket
// - a mapping setting sends program fetches to the original socket memory
// - serial link baud rate is detected automatically from the first start bit
// - the parallel host link carries data both ways
// - reset output polarity selectable, active high by default
`timescale 1ns/10ps
module ebtp_top #(
	parameter logic RESET_OUT_HIGH = ebtp_pkg::RST_OUT_HIGH, // reset output polarity
	parameter logic EXT_RESET_HIGH = 1'b0                    // external reset polarity
) (
	input  wire logic                         clk,                      // 250 MHz clock
	input  wire logic                         rst,                      // async reset
	input  wire logic [ebtp_pkg::PROBE_W-1:0] probe_pin,                // logic probes
	input  wire logic                         program_store_strobe_n,   // fetch strobe
	input  wire logic                         rd_strobe_n,              // read strobe
	input  wire logic                         wr_strobe_n,              // write strobe
	input  wire logic                         ale_pin,                  // address latch
	input  wire logic [ebtp_pkg::ADDR_W-1:0]  sock_addr,                // socket address
	input  wire logic [ebtp_pkg::DATA_W-1:0]  sock_data,                // socket data
	input  wire logic                         ext_reset_pin,            // target reset in
	input  wire logic [ebtp_pkg::PROBE_W-1:0] brk1_mask,                // break 1 care bits
	input  wire logic [ebtp_pkg::PROBE_W-1:0] brk1_value,               // break 1 pattern
	input  wire logic [ebtp_pkg::PROBE_W-1:0] brk2_mask,                // break 2 care bits
	input  wire logic [ebtp_pkg::PROBE_W-1:0] brk2_value,               // break 2 pattern
	input  wire logic                         brk_ack,                  // acknowledge pulse
	input  wire logic                         map_to_socket,            // fetch from socket
	input  wire logic                         run_req,                  // start pulse
	input  wire logic                         halt_req,                 // manual halt pulse
	input  wire logic                         cpu_reset_req,            // reset request
	input  wire logic                         rx_pin,                   // serial receive
	input  wire logic                         par_host_drives,          // host owns bus
	input  wire logic                         par_strobe_n,             // host data strobe
	input  wire logic [7:0]                   par_data_in,              // parallel in
	input  wire logic [7:0]                   par_tx_data,              // data to host
	output logic                              trace_valid,              // trace record
	output logic [ebtp_pkg::PROBE_W-1:0]      trace_probe,              // traced probes
	output logic                              first_break_event_out,    // trigger 1
	output logic                              second_break_event_out_n, // trigger 2
	output logic                              trigger_led,              // trigger lamp
	output logic                              running_led,              // running lamp
	output logic                              target_reset_out,         // reset to target
	output logic                              halt_failed,              // halt report
	output logic                              fetch_valid,              // fetch seen
	output logic [ebtp_pkg::ADDR_W-1:0]       fetch_addr,               // fetch address
	output logic                              fetch_from_socket,        // use socket memory
	output logic [ebtp_pkg::BAUD_W-1:0]       baud_div,                 // bit time cycles
	output logic                              baud_locked,              // bit time found
	output logic [7:0]                        par_rx_data,              // data from host
	output logic                              par_rx_valid,             // host byte pulse
	output logic [7:0]                        par_data_out,             // parallel out
	output logic                              par_data_oe_n             // low: device drives
);
	ebtp_cap_if cap_bus ();

	ebtp_probe_capture u_cap (
		.clk       (clk),
		.rst       (rst),
		.probe_pin (probe_pin),
		.strobe_n  ({wr_strobe_n, rd_strobe_n, program_store_strobe_n}),
		.cap       (cap_bus.src)
	);

	logic                        fe_w;
	logic [ebtp_pkg::ADDR_W-1:0] fa_w;

	ebtp_addr_rebuild u_addr (
		.clk        (clk),
		.rst        (rst),
		.sock_addr  (sock_addr),
		.sock_data  (sock_data),
		.ale_pin    (ale_pin),
		.prog_n_pin (program_store_strobe_n),
		.fetch      (fe_w),
		.fetch_addr (fa_w)
	);

	function automatic logic probe_hit(input logic [ebtp_pkg::PROBE_W-1:0] v,
		input logic [ebtp_pkg::PROBE_W-1:0] m, input logic [ebtp_pkg::PROBE_W-1:0] r);
		probe_hit = (|m) && (((v ^ r) & m) == '0);
	endfunction

	// pin synchronisers; first stage read only by the second
	logic [1:0] xr_q, rx_q, pd_q, ps_q;
	logic [7:0] pdat1_q, pdat2_q;
	logic       rx3_q, ps3_q, ext_rst;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			// idle level of the pin, so release of rst does not fake a target reset
			xr_q    <= {2{~EXT_RESET_HIGH}};
			rx_q    <= 2'h3;
			pd_q    <= 2'h0;
			ps_q    <= 2'h3;
			rx3_q   <= 1'b1;
			ps3_q   <= 1'b1;
			pdat1_q <= 8'h00;
			pdat2_q <= 8'h00;
		end else begin
			xr_q    <= {xr_q[0], ext_reset_pin};
			rx_q    <= {rx_q[0], rx_pin};
			pd_q    <= {pd_q[0], par_host_drives};
			ps_q    <= {ps_q[0], par_strobe_n};
			rx3_q   <= rx_q[1];
			ps3_q   <= ps_q[1];
			pdat1_q <= par_data_in;
			pdat2_q <= pdat1_q;
		end
	end

	assign ext_rst = (xr_q[1] == EXT_RESET_HIGH);

	// break and trace group
	logic                         b1_q, b1_d, b2_q, b2_d, b2n_q, tv_q, tv_d, hit1, hit2;
	logic [ebtp_pkg::PROBE_W-1:0] tp_q, tp_d;

	assign hit1 = cap_bus.valid && probe_hit(cap_bus.probe, brk1_mask, brk1_value);
	assign hit2 = cap_bus.valid && probe_hit(cap_bus.probe, brk2_mask, brk2_value);

	always_comb begin
		tv_d = cap_bus.valid;
		tp_d = cap_bus.valid ? cap_bus.probe : tp_q;
		// a new hit wins over a same-cycle acknowledge; reset state is ignored here
		b1_d = hit1 | (b1_q & ~brk_ack);
		b2_d = hit2 | (b2_q & ~brk_ack);
	end

	// execution control group
	ebtp_pkg::ebtp_exec_t st_q, st_d;
	logic                 run_q, run_d, hf_q, hf_d, hw_q, hw_d, ro_q, ro_d;

	always_comb begin
		st_d = st_q;
		hf_d = 1'b0;
		hw_d = 1'b0;
		case (st_q)
			ebtp_pkg::EBTP_IDLE: begin
				if (run_req) begin
					st_d = ext_rst ? ebtp_pkg::EBTP_HOLD : ebtp_pkg::EBTP_RUN;
				end
			end
			ebtp_pkg::EBTP_RUN: begin
				if (halt_req) begin
					st_d = ebtp_pkg::EBTP_IDLE;
				end else if (ext_rst) begin
					st_d = ebtp_pkg::EBTP_HOLD;
				end
			end
			ebtp_pkg::EBTP_HOLD: begin
				if (halt_req) begin
					st_d = ebtp_pkg::EBTP_IDLE;
					hf_d = 1'b1;
					hw_d = 1'b1;
				end else if (!ext_rst) begin
					st_d = ebtp_pkg::EBTP_RUN;
				end
			end
			default: begin
				st_d = ebtp_pkg::EBTP_IDLE;
			end
		endcase
		run_d = (st_d == ebtp_pkg::EBTP_RUN);
		// processor held in reset by target reset, host request or forced reset
		ro_d  = ext_rst | cpu_reset_req | hw_d;
	end

	// adapter fetch routing, serial detection and parallel link group
	logic                        fv_q, fs_q, lk_q, lk_d, mes_q, mes_d, pv_q, pv_d, oe_q;
	logic [ebtp_pkg::ADDR_W-1:0] fa_q;
	logic [ebtp_pkg::BAUD_W-1:0] bd_q, bd_d, cnt_q, cnt_d;
	logic [7:0]                  pr_q, pr_d, po_q;

	always_comb begin
		lk_d  = lk_q;
		mes_d = mes_q;
		bd_d  = bd_q;
		cnt_d = cnt_q;
		// first start bit width gives the bit time; frame is fixed 8N1
		if (!lk_q && !mes_q && rx3_q && !rx_q[1]) begin
			mes_d = 1'b1;
			cnt_d = ebtp_pkg::BAUD_ONE;
		end else if (mes_q && !rx_q[1]) begin
			cnt_d = (cnt_q == ebtp_pkg::BAUD_MAX) ? cnt_q : cnt_q + ebtp_pkg::BAUD_ONE;
		end else if (mes_q) begin
			mes_d = 1'b0;
			lk_d  = 1'b1;
			bd_d  = cnt_q;
		end
		pv_d = ps3_q && !ps_q[1] && pd_q[1];
		pr_d = pv_d ? pdat2_q : pr_q;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tv_q  <= 1'b0;
			tp_q  <= ebtp_pkg::PROBE_RST;
			b1_q  <= 1'b0;
			b2_q  <= 1'b0;
			b2n_q <= 1'b1;
			st_q  <= ebtp_pkg::EBTP_IDLE;
			run_q <= 1'b0;
			hf_q  <= 1'b0;
			hw_q  <= 1'b0;
			ro_q  <= ~RESET_OUT_HIGH;
			fv_q  <= 1'b0;
			fa_q  <= ebtp_pkg::ADDR_RST;
			fs_q  <= 1'b0;
			lk_q  <= 1'b0;
			mes_q <= 1'b0;
			bd_q  <= ebtp_pkg::BAUD_RST;
			cnt_q <= ebtp_pkg::BAUD_RST;
			pv_q  <= 1'b0;
			pr_q  <= 8'h00;
			po_q  <= 8'h00;
			oe_q  <= 1'b1;
		end else begin
			tv_q  <= tv_d;
			tp_q  <= tp_d;
			b1_q  <= b1_d;
			b2_q  <= b2_d;
			b2n_q <= ~b2_d;
			st_q  <= st_d;
			run_q <= run_d;
			hf_q  <= hf_d;
			hw_q  <= hw_d;
			ro_q  <= RESET_OUT_HIGH ? ro_d : ~ro_d;
			fv_q  <= fe_w;
			fa_q  <= fa_w;
			fs_q  <= fe_w & map_to_socket;
			lk_q  <= lk_d;
			mes_q <= mes_d;
			bd_q  <= bd_d;
			cnt_q <= cnt_d;
			pv_q  <= pv_d;
			pr_q  <= pr_d;
			po_q  <= par_tx_data;
			oe_q  <= pd_q[1];
		end
	end

	// trigger 1 is the break flop itself and trigger 2 an inverted flop loaded from b2_d, so no extra cycle is added
	assign trace_valid              = tv_q;
	assign trace_probe              = tp_q;
	assign first_break_event_out    = b1_q;
	assign second_break_event_out_n = b2n_q;
	assign trigger_led              = b1_q;
	assign running_led              = run_q;
	// polarity is applied ahead of the flop, so the pin comes straight from a register
	assign target_reset_out         = ro_q;
	assign halt_failed              = hf_q;
	assign fetch_valid              = fv_q;
	assign fetch_addr               = fa_q;
	assign fetch_from_socket        = fs_q;
	assign baud_div                 = bd_q;
	assign baud_locked              = lk_q;
	assign par_rx_data              = pr_q;
	assign par_rx_valid             = pv_q;
	assign par_data_out             = po_q;
	assign par_data_oe_n            = oe_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_hold_halt;
		(st_q == ebtp_pkg::EBTP_HOLD) ##0 halt_req;
	endsequence
	sequence s_forced_reset;
		hf_q && hw_q ##0 (target_reset_out == RESET_OUT_HIGH) ##1 !hf_q;
	endsequence

	a_trig1_on_hit: assert property (hit1 |=> first_break_event_out) else $error("trigger 1 missed");
	a_trig2_low_hit: assert property (hit2 |=> !second_break_event_out_n) else $error("trigger 2 missed");
	a_trig_hold_ack: assert property (first_break_event_out && !brk_ack && !hit1 |=> first_break_event_out)
		else $error("trigger 1 dropped early");
	a_trig_clear_ack: assert property (brk_ack && !hit2 |=> second_break_event_out_n)
		else $error("trigger 2 not cleared");
	a_led_mirror: assert property (trigger_led == first_break_event_out) else $error("indicator differs");
	a_no_hit_uncap: assert property (!cap_bus.valid |=> !$rose(b1_q) && !$rose(b2_q))
		else $error("break without capture");
	a_dark_in_reset: assert property (ext_rst [*2] |-> !running_led) else $error("running lit in reset");
	a_halt_fail_rep: assert property (s_hold_halt |=> s_forced_reset) else $error("halt failure not reported");
	a_reset_follows: assert property (ext_rst |=> (target_reset_out == RESET_OUT_HIGH))
		else $error("target reset not driven");
	a_socket_fetch: assert property (fe_w && map_to_socket |=> fetch_from_socket ##1 !fetch_from_socket)
		else $error("socket fetch not flagged");
	a_break_in_reset: assert property (ext_rst && hit2 |=> !second_break_event_out_n)
		else $error("break lost under reset");
endmodule // ebtp_top

// ===== verification/ebtp_target_model.sv
// target side model: bus strobes, logic probes, address latch, socket lines and reset input
`timescale 1ns/10ps
module ebtp_target_model (
	input  wire logic   clk,                    // system clock
	input  wire logic   target_reset_out,       // reset from the emulator
	output logic [11:0] probe_pin,              // logic probes
	output logic        program_store_strobe_n, // fetch strobe
	output logic        rd_strobe_n,            // read strobe
	output logic        wr_strobe_n,            // write strobe
	output logic        ale_pin,                // address latch strobe
	output logic [15:0] sock_addr,              // socket address
	output logic [7:0]  sock_data,              // socket data
	output logic        ext_reset_pin_n         // reset into the emulator
);
	logic [2:0] strb_n;
	logic       cpu_held;
	assign {wr_strobe_n, rd_strobe_n, program_store_strobe_n} = strb_n;
	// the processor reset pin follows the emulator output, kept for waveform reading
	assign cpu_held = target_reset_out;
	initial begin
		strb_n = 3'h7;
		probe_pin = 12'h000;
		ale_pin = 1'b0;
		sock_addr = 16'h0000;
		sock_data = 8'h00;
		ext_reset_pin_n = 1'b1;
	end
	task automatic set_probe(input logic [11:0] p);
		@(negedge clk);
		probe_pin = p;
	endtask
	// probes settle a cycle ahead of the strobe so they leave the synchronisers a cycle before the fall is seen
	task automatic strobe_fall(input int kind, input logic [11:0] p);
		set_probe(p);
		@(negedge clk);
		strb_n[kind] = 1'b0;
	endtask
	task automatic strobe_rise();
		@(negedge clk);
		strb_n = 3'h7;
		probe_pin = ~probe_pin;
		@(negedge clk);
	endtask
	task automatic latch_addr(input logic [15:0] a, input logic [7:0] lo);
		@(negedge clk);
		sock_data = lo;
		ale_pin = 1'b1;
		repeat (3) @(negedge clk);
		ale_pin = 1'b0;
		repeat (3) @(negedge clk);
		// the low byte leaves the multiplexed bus once latched
		sock_data = ~lo;
		sock_addr = a;
		@(negedge clk);
		strb_n[0] = 1'b0;
	endtask
	task automatic drive_ext_reset(input logic on);
		@(negedge clk);
		ext_reset_pin_n = ~on;
	endtask
endmodule // ebtp_target_model

// ===== verification/ebtp_top_tb.sv
// self-checking bench of the break and trace probe logic
`timescale 1ns/10ps
module ebtp_top_tb;
	logic        clk, rst, program_store_strobe_n, rd_strobe_n, wr_strobe_n, ale_pin, ext_reset_pin_n;
	logic [11:0] probe_pin, brk1_mask, brk1_value, brk2_mask, brk2_value, trace_probe;
	logic        brk_ack, map_to_socket, run_req, halt_req, cpu_reset_req, rx_pin;
	logic        par_host_drives, par_strobe_n, trace_valid, first_break_event_out, second_break_event_out_n;
	logic        trigger_led, running_led, target_reset_out, halt_failed, fetch_valid, fetch_from_socket;
	logic        baud_locked, par_rx_valid, par_data_oe_n;
	logic [15:0] sock_addr, fetch_addr, baud_div;
	logic [7:0]  sock_data, par_data_in, par_tx_data, par_rx_data, par_data_out;
	logic [31:0] rnd_state, r;
	int          error_cnt, compares, i;
	logic [11:0] p;
	logic        e1, e2;
	localparam int KIND_RD_SEL = ebtp_pkg::KIND_RD;

	ebtp_top dut_u (.clk(clk), .rst(rst), .probe_pin(probe_pin), .program_store_strobe_n(program_store_strobe_n),
		.rd_strobe_n(rd_strobe_n), .wr_strobe_n(wr_strobe_n), .ale_pin(ale_pin), .sock_addr(sock_addr),
		.sock_data(sock_data), .ext_reset_pin(ext_reset_pin_n), .brk1_mask(brk1_mask), .brk1_value(brk1_value),
		.brk2_mask(brk2_mask), .brk2_value(brk2_value), .brk_ack(brk_ack), .map_to_socket(map_to_socket),
		.run_req(run_req), .halt_req(halt_req), .cpu_reset_req(cpu_reset_req), .rx_pin(rx_pin),
		.par_host_drives(par_host_drives), .par_strobe_n(par_strobe_n), .par_data_in(par_data_in),
		.par_tx_data(par_tx_data), .trace_valid(trace_valid), .trace_probe(trace_probe),
		.first_break_event_out(first_break_event_out), .second_break_event_out_n(second_break_event_out_n),
		.trigger_led(trigger_led), .running_led(running_led), .target_reset_out(target_reset_out),
		.halt_failed(halt_failed), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
		.fetch_from_socket(fetch_from_socket), .baud_div(baud_div), .baud_locked(baud_locked),
		.par_rx_data(par_rx_data), .par_rx_valid(par_rx_valid), .par_data_out(par_data_out),
		.par_data_oe_n(par_data_oe_n));
	ebtp_target_model tgt_u (.clk(clk), .target_reset_out(target_reset_out), .probe_pin(probe_pin),
		.program_store_strobe_n(program_store_strobe_n), .rd_strobe_n(rd_strobe_n), .wr_strobe_n(wr_strobe_n),
		.ale_pin(ale_pin), .sock_addr(sock_addr), .sock_data(sock_data), .ext_reset_pin_n(ext_reset_pin_n));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	function automatic logic [31:0] xs();
		rnd_state = rnd_state ^ (rnd_state << 13);
		rnd_state = rnd_state ^ (rnd_state >> 17);
		rnd_state = rnd_state ^ (rnd_state << 5);
		return rnd_state;
	endfunction
	function automatic logic hit(input logic [11:0] m, input logic [11:0] v, input logic [11:0] q);
		return (m != 12'h000) && (((q ^ v) & m) == 12'h000);
	endfunction
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic conclude();
		if (error_cnt == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// bounded wait for a design output, sampled just after the rising edge
	task automatic wait_sig(input int sel);
		logic s;
		int   n;
		s = 1'b0;
		for (n = 0; n < 20 && s !== 1'b1; n++) begin
			@(posedge clk);
			#1;
			case (sel)
				0: s = trace_valid;
				1: s = fetch_valid;
				2: s = target_reset_out;
				3: s = par_rx_valid;
				default: s = baud_locked;
			endcase
		end
		if (s !== 1'b1) begin
			error_cnt++;
			conclude();
		end
	endtask
	task automatic ack_and_check();
		@(negedge clk);
		brk_ack = 1'b1;
		@(negedge clk);
		brk_ack = 1'b0;
		check("trig1_cleared", first_break_event_out, 1'b0);
		check("trig2_cleared", second_break_event_out_n, 1'b1);
	endtask
	task automatic hit_cycle(input int kind);
		tgt_u.strobe_fall(kind, p);
		wait_sig(0);
		check("trace_probe", trace_probe, p);
		check("trig1", first_break_event_out, e1);
		check("trig2_n", second_break_event_out_n, !e2);
		check("trig_led", trigger_led, e1);
		tgt_u.strobe_rise();
		check("trig1_held", first_break_event_out, e1);
		ack_and_check();
	endtask

	initial begin
		rnd_state = 32'hA8DAA21D;
		error_cnt = 0;
		compares = 0;
		rst = 1'b1;
		{brk1_mask, brk1_value, brk2_mask, brk2_value} = 48'h0;
		{brk_ack, map_to_socket, run_req, halt_req, cpu_reset_req, par_host_drives} = 6'h00;
		rx_pin = 1'b1;
		par_strobe_n = 1'b1;
		par_data_in = 8'h00;
		par_tx_data = 8'h00;
		repeat (2) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		check("reset_out_idle", target_reset_out, 1'b0);
		check("trig2_idle", second_break_event_out_n, 1'b1);
		check("par_oe_idle", par_data_oe_n, 1'b1);
		for (i = 0; i < 6; i++) begin
			r = xs();
			p = r[11:0];
			@(negedge clk);
			brk1_mask = r[23:12];
			brk1_value = (i < 3) ? p : ~p;
			brk2_mask = (i == 1) ? 12'h000 : 12'hFFF;
			brk2_value = (i % 2 == 0) ? p : ~p;
			e1 = hit(brk1_mask, brk1_value, p);
			e2 = hit(brk2_mask, brk2_value, p);
			hit_cycle(i % 3);
		end
		// probe level that matches but is never strobed must not break
		p = 12'h5A5;
		brk1_mask = 12'hFFF;
		brk1_value = p;
		brk2_mask = 12'h000;
		tgt_u.set_probe(p);
		repeat (8) @(posedge clk);
		#1;
		check("no_strobe_break", first_break_event_out, 1'b0);
		@(negedge clk);
		run_req = 1'b1;
		@(negedge clk);
		run_req = 1'b0;
		check("running", running_led, 1'b1);
		tgt_u.drive_ext_reset(1'b1);
		wait_sig(2);
		check("running_dark", running_led, 1'b0);
		e1 = 1'b1;
		e2 = 1'b0;
		hit_cycle(KIND_RD_SEL);
		@(negedge clk);
		halt_req = 1'b1;
		@(posedge clk);
		#1;
		check("halt_failed", halt_failed, 1'b1);
		check("halt_hw_reset", target_reset_out, 1'b1);
		@(negedge clk);
		halt_req = 1'b0;
		tgt_u.drive_ext_reset(1'b0);
		repeat (6) @(negedge clk);
		check("reset_released", target_reset_out, 1'b0);
		cpu_reset_req = 1'b1;
		wait_sig(2);
		@(negedge clk);
		cpu_reset_req = 1'b0;
		brk1_mask = 12'h000;
		for (i = 0; i < 2; i++) begin
			r = xs();
			map_to_socket = (i == 0);
			tgt_u.latch_addr(r[15:0], r[23:16]);
			wait_sig(1);
			check("fetch_addr", fetch_addr, {r[15:8], r[23:16]});
			check("fetch_socket", fetch_from_socket, (i == 0));
			tgt_u.strobe_rise();
		end
		// start bit held low for exactly 40 clock cycles
		@(negedge clk);
		rx_pin = 1'b0;
		repeat (40) @(negedge clk);
		rx_pin = 1'b1;
		wait_sig(4);
		check("baud_div", baud_div, 16'h0028);
		r = xs();
		@(negedge clk);
		par_host_drives = 1'b1;
		par_data_in = r[7:0];
		repeat (4) @(negedge clk);
		check("par_oe_host", par_data_oe_n, 1'b1);
		par_strobe_n = 1'b0;
		wait_sig(3);
		check("par_rx_data", par_rx_data, r[7:0]);
		@(negedge clk);
		par_strobe_n = 1'b1;
		par_host_drives = 1'b0;
		par_tx_data = r[15:8];
		repeat (4) @(negedge clk);
		check("par_oe_dev", par_data_oe_n, 1'b0);
		check("par_data_out", par_data_out, r[15:8]);
		conclude();
	end
	initial begin
		#200000;
		error_cnt++;
		conclude();
	end
endmodule // ebtp_top_tb
